/* pmr_ctrl.sv */
// Purpose: power mode control and reset sequencing
// Assumes: rst_n_i is the power-on detector; clock keeps running
// Notes: osc_run_o low only tells the oscillator to stop
//
// Functional notes
// - six software flag bits, no effect
// - stop bit enters stop, reads zero
// - idle bit gates cpu clock, reads zero
// - power_control at 0x87, resets to zero
// - reset halts core, loads registers, quiets ports
// - data memory kept, stack pointer reset
// - port latches all ones, open drain, pullups
// - power-on and monitor resets drive pin low
// - exit: boot zero, internal clock, watchdog /12
// - hold extra release delay after power-up
// - power-up flag set on exit, others clear
// - monitor on after power-on, else kept
// - low supply holds reset, drives pin
// - no release delay after monitor reset
// - modes start after the setting instruction
// - idle ends on interrupt or reset
// - stop ends only by reset
`timescale 1ns/10ps
module pmr_ctrl #(
    parameter int POR_DELAY_CYC = pmr_pkg::PMR_POR_DELAY_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic supply_ok_i,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_n_o,
    input wire logic other_rst_i,
    input wire logic instr_done_i,
    input wire logic irq_pending_i,
    output logic core_reset_o,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic osc_run_o,
    output logic port_force_o,
    output logic [7:0] port_latch_o,
    output logic reset_exit_o,
    output logic [15:0] boot_addr_o,
    output logic [3:0] wdt_div_o,
    output logic clk_int_sel_o
);
    import pmr_pkg::*;

    // --------------------------------------------------
    // state
    // --------------------------------------------------
    typedef struct packed {
        pmr_state_t state;
        pmr_cause_t cause;
        logic [PMR_GF_W-1:0] gf;
        logic idle_pend;
        logic stop_pend;
        logic mon_on;
        logic mon_sel;
        logic por_flag;
        logic pin_flag;
        logic sw_flag;
        logic sw_req;
        logic dly_start;
        logic [7:0] rdata;
        logic core_rst;
        logic cpu_en;
        logic per_en;
        logic osc_run;
        logic pin_oe_n;
        logic [1:0] pin_echo;
        logic [7:0] port_latch;
        logic exit_p;
    } pmr_ctrl_t;

    pmr_ctrl_t st_reg;
    pmr_ctrl_t st_next;
    logic [1:0] pin_sync;
    logic sup_ok_s;
    logic pin_hi_s;
    logic dly_done;
    logic mon_trip;
    logic pin_req;
    logic req_any;
    logic wr_pc;
    logic wr_mc;
    logic wr_ro;

    // --------------------------------------------------
    // pin-side levels and release delay
    // --------------------------------------------------
    // reset value high so a quiet pin is not seen as a reset
    pmr_sync #(
        .W(2)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({supply_ok_i, rst_pin_i}),
        .rst_val_i(2'b01),
        .sync_o(pin_sync)
    );

    pmr_delay #(
        .CYCLES(POR_DELAY_CYC)
    ) u_dly (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(st_reg.dly_start),
        .done_o(dly_done)
    );

    assign sup_ok_s = pin_sync[1];
    assign pin_hi_s = pin_sync[0];

    // --------------------------------------------------
    // reset requests and write decode
    // --------------------------------------------------
    // the monitor trips only when on and selected as a source
    assign mon_trip = st_reg.mon_on & st_reg.mon_sel & ~sup_ok_s;
    // sources merged into one internal request
    // our own drive echoes back through the syncs; masked for two more edges
    assign pin_req = ~pin_hi_s & st_reg.pin_oe_n & ~|st_reg.pin_echo;
    assign req_any = mon_trip | pin_req | other_rst_i | st_reg.sw_req;
    // writes are ignored while the core is held
    always_comb begin
        wr_pc = 1'b0;
        wr_mc = 1'b0;
        wr_ro = 1'b0;
        if (sfr_wr_i && !st_reg.core_rst) begin
            if (sfr_addr_i == PMR_ADDR_PWR_CTRL) begin
                wr_pc = 1'b1;
            end else if (sfr_addr_i == PMR_ADDR_MON_CTRL) begin
                wr_mc = 1'b1;
            end else if (sfr_addr_i == PMR_ADDR_ORIGIN) begin
                wr_ro = 1'b1;
            end
        end
    end

    // --------------------------------------------------
    // next-state logic
    // --------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.dly_start = 1'b0;
        st_next.exit_p = 1'b0;
        st_next.sw_req = 1'b0;

        // register writes
        if (wr_pc) begin
            st_next.gf = sfr_wdata_i[PMR_PC_GF_LSB +: PMR_GF_W];
            if (sfr_wdata_i[PMR_PC_STOP_BIT]) begin
                st_next.stop_pend = 1'b1;
            end
            if (sfr_wdata_i[PMR_PC_IDLE_BIT]) begin
                st_next.idle_pend = 1'b1;
            end
        end
        if (wr_mc) begin
            st_next.mon_on = sfr_wdata_i[PMR_MC_ON_BIT];
        end
        if (wr_ro) begin
            st_next.mon_sel = sfr_wdata_i[PMR_RO_POR_BIT];
            st_next.sw_req = sfr_wdata_i[PMR_RO_SW_BIT];
        end

        // sequencer
        case (st_reg.state)
            PMR_ST_HOLD: begin
                // supply low while holding power-on keeps power-on
                if (st_reg.cause == PMR_C_POR) begin
                    if (sup_ok_s) begin
                        st_next.state = PMR_ST_DLY;
                        st_next.dly_start = 1'b1;
                    end
                end else if (mon_trip) begin
                    st_next.cause = PMR_C_MON;
                end else if (pin_req) begin
                    st_next.cause = PMR_C_PIN;
                end else if (!other_rst_i) begin
                    // monitor release skips the power-up delay
                    st_next.state = PMR_ST_RUN;
                    st_next.exit_p = 1'b1;
                    st_next.por_flag = 1'b0;
                    st_next.pin_flag = (st_reg.cause == PMR_C_PIN);
                    st_next.sw_flag = (st_reg.cause == PMR_C_SW);
                end
            end
            PMR_ST_DLY: begin
                if (!sup_ok_s) begin
                    st_next.state = PMR_ST_HOLD;
                end else if (dly_done) begin
                    st_next.state = PMR_ST_RUN;
                    st_next.exit_p = 1'b1;
                    st_next.por_flag = 1'b1;
                end
            end
            PMR_ST_RUN: begin
                // entry waits for the setting instruction to end
                if (instr_done_i && (st_next.stop_pend)) begin
                    st_next.state = PMR_ST_STOP;
                    st_next.stop_pend = 1'b0;
                    st_next.idle_pend = 1'b0;
                end else if (instr_done_i && st_next.idle_pend) begin
                    st_next.state = PMR_ST_IDLE;
                    st_next.idle_pend = 1'b0;
                end
            end
            PMR_ST_IDLE: begin
                if (irq_pending_i) begin
                    st_next.state = PMR_ST_RUN;
                end
            end
            PMR_ST_STOP: begin
                st_next.state = PMR_ST_STOP;
            end
            default: begin
                st_next.state = PMR_ST_HOLD;
            end
        endcase

        // any request outside hold/delay enters reset
        if (req_any && st_reg.state != PMR_ST_HOLD && st_reg.state != PMR_ST_DLY) begin
            st_next.state = PMR_ST_HOLD;
            if (mon_trip) begin
                st_next.cause = PMR_C_MON;
            end else if (pin_req) begin
                st_next.cause = PMR_C_PIN;
            end else if (st_reg.sw_req) begin
                st_next.cause = PMR_C_SW;
            end else begin
                st_next.cause = PMR_C_OTH;
            end
        end

        // registers load reset values while held; monitor kept
        if (st_next.state == PMR_ST_HOLD) begin
            st_next.gf = PMR_PWR_CTRL_RST[PMR_PC_GF_LSB +: PMR_GF_W];
            st_next.idle_pend = 1'b0;
            st_next.stop_pend = 1'b0;
        end

        // outputs follow the next state
        st_next.core_rst = (st_next.state == PMR_ST_HOLD) || (st_next.state == PMR_ST_DLY);
        st_next.cpu_en = (st_next.state == PMR_ST_RUN);
        st_next.per_en = (st_next.state != PMR_ST_STOP);
        st_next.osc_run = (st_next.state != PMR_ST_STOP);
        st_next.pin_oe_n = !(st_next.core_rst
            && (st_next.cause == PMR_C_POR || st_next.cause == PMR_C_MON));
        st_next.pin_echo = {st_reg.pin_echo[0], !st_reg.pin_oe_n};
        if (st_next.core_rst) begin
            st_next.port_latch = PMR_PORT_RST_VAL;
        end

        // read data; mode-select bits always read zero
        if (sfr_rd_i) begin
            if (sfr_addr_i == PMR_ADDR_PWR_CTRL) begin
                st_next.rdata = {st_reg.gf, 2'b00};
            end else if (sfr_addr_i == PMR_ADDR_MON_CTRL) begin
                st_next.rdata = PMR_READ_ZERO;
                st_next.rdata[PMR_MC_ON_BIT] = st_reg.mon_on;
                st_next.rdata[PMR_MC_STAT_BIT] = sup_ok_s;
            end else if (sfr_addr_i == PMR_ADDR_ORIGIN) begin
                st_next.rdata = PMR_READ_ZERO;
                st_next.rdata[PMR_RO_PIN_BIT] = st_reg.pin_flag;
                st_next.rdata[PMR_RO_POR_BIT] = st_reg.por_flag;
                st_next.rdata[PMR_RO_SW_BIT] = st_reg.sw_flag;
            end else begin
                st_next.rdata = PMR_READ_ZERO;
            end
        end
    end

    // --------------------------------------------------
    // state register
    // --------------------------------------------------
    // power-on: monitor enabled and selected, delay pending
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_reg.state <= PMR_ST_HOLD;
            st_reg.cause <= PMR_C_POR;
            st_reg.gf <= '0;
            st_reg.idle_pend <= 1'b0;
            st_reg.stop_pend <= 1'b0;
            st_reg.mon_on <= 1'b1;
            st_reg.mon_sel <= 1'b1;
            st_reg.por_flag <= 1'b0;
            st_reg.pin_flag <= 1'b0;
            st_reg.sw_flag <= 1'b0;
            st_reg.sw_req <= 1'b0;
            st_reg.dly_start <= 1'b0;
            st_reg.rdata <= '0;
            st_reg.core_rst <= 1'b1;
            st_reg.cpu_en <= 1'b0;
            st_reg.per_en <= 1'b1;
            st_reg.osc_run <= 1'b1;
            st_reg.pin_oe_n <= 1'b0;
            st_reg.pin_echo <= 2'b11;
            st_reg.port_latch <= PMR_PORT_RST_VAL;
            st_reg.exit_p <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // --------------------------------------------------
    // outputs
    // --------------------------------------------------
    // boot values are constants presented with the exit pulse
    assign sfr_rdata_o = st_reg.rdata;
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_n_o = st_reg.pin_oe_n;
    assign core_reset_o = st_reg.core_rst;
    assign cpu_clk_en_o = st_reg.cpu_en;
    assign periph_clk_en_o = st_reg.per_en;
    assign osc_run_o = st_reg.osc_run;
    assign port_force_o = st_reg.core_rst;
    assign port_latch_o = st_reg.port_latch;
    assign reset_exit_o = st_reg.exit_p;
    assign boot_addr_o = PMR_BOOT_ADDR;
    assign wdt_div_o = PMR_WDT_DIV;
    assign clk_int_sel_o = st_reg.exit_p;
endmodule

/* pmr_pkg.sv */
// Purpose: constants and types for the power mode and reset block
// Assumes: byte-wide special-function register port, 100 MHz clock
// Notes: offsets are special-function addresses, not byte lanes
package pmr_pkg;
    // register addresses
    localparam logic [7:0] PMR_ADDR_PWR_CTRL = 8'h87;
    localparam logic [7:0] PMR_ADDR_MON_CTRL = 8'hFF;
    localparam logic [7:0] PMR_ADDR_ORIGIN = 8'hEF;
    // power_control fields
    localparam int PMR_PC_IDLE_BIT = 0;
    localparam int PMR_PC_STOP_BIT = 1;
    localparam int PMR_PC_GF_LSB = 2;
    localparam int PMR_GF_W = 6;
    localparam logic [7:0] PMR_PWR_CTRL_RST = 8'h00;
    // supply_monitor_control fields
    localparam int PMR_MC_ON_BIT = 7;
    localparam int PMR_MC_STAT_BIT = 6;
    // reset_origin_register fields
    localparam int PMR_RO_PIN_BIT = 0;
    localparam int PMR_RO_POR_BIT = 1;
    localparam int PMR_RO_SW_BIT = 4;
    // values loaded while and after reset
    localparam logic [7:0] PMR_PORT_RST_VAL = 8'hFF;
    localparam logic [15:0] PMR_BOOT_ADDR = 16'h0000;
    localparam logic [3:0] PMR_WDT_DIV = 4'hC;
    localparam logic [7:0] PMR_READ_ZERO = 8'h00;
    // power-up release delay
    localparam int PMR_CLK_MHZ = 100;
    localparam int PMR_POR_DELAY_MS = 10;
    localparam int PMR_POR_DELAY_CYC = PMR_POR_DELAY_MS * 1000 * PMR_CLK_MHZ;
    localparam int PMR_CNT_W = 24;
    // sequencer states, gray along hold-delay-run-idle-stop
    typedef enum logic [2:0] {
        PMR_ST_HOLD = 3'b000,
        PMR_ST_DLY = 3'b001,
        PMR_ST_RUN = 3'b011,
        PMR_ST_IDLE = 3'b010,
        PMR_ST_STOP = 3'b110
    } pmr_state_t;
    // origin of the reset being held
    typedef enum logic [2:0] {
        PMR_C_POR = 3'b000,
        PMR_C_MON = 3'b001,
        PMR_C_PIN = 3'b010,
        PMR_C_OTH = 3'b011,
        PMR_C_SW = 3'b100
    } pmr_cause_t;
endpackage

/* pmr_sync.sv */
// Purpose: two-flop synchroniser for pin-side levels
// Assumes: inputs are slow levels, not pulses
// Notes: only the second stage leaves this module
`timescale 1ns/10ps
module pmr_sync #(
    parameter int W = 2
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    input wire logic [W-1:0] rst_val_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pmr_sync_t;
    pmr_sync_t st_reg;
    pmr_sync_t st_next;

    // -------------------------------------------------
    // two stages per bit
    // -------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            st_next.s1[i] = async_i[i];
            st_next.s2[i] = st_reg.s1[i];
        end
    end

    // synchronous reset; stages settle on a few edges after release
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_reg.s1 <= rst_val_i;
            st_reg.s2 <= rst_val_i;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_o = st_reg.s2;
endmodule

/* pmr_delay.sv */
// Purpose: one-shot release delay counter
// Assumes: start_i is a one-cycle pulse
// Notes: done_o pulses once, CYCLES edges after start
`timescale 1ns/10ps
module pmr_delay #(
    parameter int CYCLES = 1000000
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    output logic done_o
);
    import pmr_pkg::*;
    typedef struct packed {
        logic [PMR_CNT_W-1:0] cnt;
        logic run;
        logic done;
    } pmr_dly_t;
    pmr_dly_t st_reg;
    pmr_dly_t st_next;
    localparam logic [PMR_CNT_W-1:0] LAST = PMR_CNT_W'(CYCLES - 1);

    // count up from start, pulse done at the end
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (start_i) begin
            st_next.cnt = '0;
            st_next.run = 1'b1;
        end else if (st_reg.run) begin
            if (st_reg.cnt == LAST) begin
                st_next.run = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign done_o = st_reg.done;
endmodule

/* pmr_rail_model.sv */
// Purpose: supply rail and external reset circuit for pmr_ctrl
// Assumes: pin has a pull-up; the design only ever pulls it low
// Notes: supply status lags the rail off the clock grid
`timescale 1ns/10ps
module pmr_rail_model (
    input wire logic supply_up_i,
    input wire logic ext_hold_i,
    input wire logic drv_i,
    input wire logic oe_n_i,
    output logic supply_ok_o,
    output logic pin_o
);
    // comparator output, async so the sync stages see a real crossing
    initial supply_ok_o = 1'b0;
    always @(supply_up_i) supply_ok_o <= #3 supply_up_i;
    // wired-and of device drive and external switch, pull-up otherwise
    assign pin_o = ((!oe_n_i && !drv_i) || ext_hold_i) ? 1'b0 : 1'b1;
endmodule

/* pmr_ctrl_assertions.sv */
// Purpose: port-level checks of the power mode and reset block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every pmr_ctrl instance
`timescale 1ns/10ps
module pmr_ctrl_assertions
import pmr_pkg::*;
#(
    parameter int POR_DELAY_CYC = 20
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic supply_ok_i,
    input wire logic rst_pin_i,
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe_n_o,
    input wire logic other_rst_i,
    input wire logic instr_done_i,
    input wire logic irq_pending_i,
    input wire logic core_reset_o,
    input wire logic cpu_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic osc_run_o,
    input wire logic port_force_o,
    input wire logic [7:0] port_latch_o,
    input wire logic reset_exit_o,
    input wire logic [15:0] boot_addr_o,
    input wire logic [3:0] wdt_div_o,
    input wire logic clk_int_sel_o
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_pin_in_reset;
        !rst_pin_oe_n_o |-> core_reset_o;
    endproperty
    a_pin_in_reset: assert property (p_pin_in_reset) else $error("pin driven outside reset");
    property p_ports_known;
        core_reset_o |-> port_force_o && port_latch_o == PMR_PORT_RST_VAL;
    endproperty
    a_ports_known: assert property (p_ports_known) else $error("ports not forced in reset");
    property p_halt;
        core_reset_o |-> !cpu_clk_en_o;
    endproperty
    a_halt: assert property (p_halt) else $error("cpu clocked in reset");
    property p_exit_vals;
        $fell(core_reset_o) |-> reset_exit_o && clk_int_sel_o && boot_addr_o == PMR_BOOT_ADDR && wdt_div_o == PMR_WDT_DIV;
    endproperty
    a_exit_vals: assert property (p_exit_vals) else $error("exit values wrong");
    property p_exit_pulse;
        reset_exit_o |=> !reset_exit_o && !core_reset_o;
    endproperty
    a_exit_pulse: assert property (p_exit_pulse) else $error("exit pulse too long");
    property p_mode_read_zero;
        sfr_rd_i && sfr_addr_i == PMR_ADDR_PWR_CTRL |=> sfr_rdata_o[1:0] == 2'b00;
    endproperty
    a_mode_read_zero: assert property (p_mode_read_zero) else $error("mode bits read set");
    property p_after_instr;
        $fell(cpu_clk_en_o) && !core_reset_o |-> $past(instr_done_i);
    endproperty
    a_after_instr: assert property (p_after_instr) else $error("mode entered mid instruction");
    property p_stop_holds;
        $rose(osc_run_o) |-> core_reset_o;
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("stop left without reset");
    property p_idle_wake;
        !cpu_clk_en_o && osc_run_o && !core_reset_o && irq_pending_i && !other_rst_i |=> cpu_clk_en_o;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle not left on interrupt");
    property p_idle_periph;
        !cpu_clk_en_o && osc_run_o |-> periph_clk_en_o;
    endproperty
    a_idle_periph: assert property (p_idle_periph) else $error("peripherals stopped in idle");
    property p_stop_clocks;
        !osc_run_o |-> !periph_clk_en_o && !cpu_clk_en_o;
    endproperty
    a_stop_clocks: assert property (p_stop_clocks) else $error("clocks running in stop");
    // main scenarios seen
    c_exit: cover property (reset_exit_o);
    c_idle: cover property (!cpu_clk_en_o && osc_run_o && !core_reset_o);
    c_stop: cover property (!osc_run_o);
endmodule
bind pmr_ctrl pmr_ctrl_assertions #(.POR_DELAY_CYC(POR_DELAY_CYC)) pmr_ctrl_assertions_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .supply_ok_i(supply_ok_i),
    .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(rst_pin_oe_n_o), .other_rst_i(other_rst_i),
    .instr_done_i(instr_done_i), .irq_pending_i(irq_pending_i), .core_reset_o(core_reset_o),
    .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o), .osc_run_o(osc_run_o),
    .port_force_o(port_force_o), .port_latch_o(port_latch_o), .reset_exit_o(reset_exit_o),
    .boot_addr_o(boot_addr_o), .wdt_div_o(wdt_div_o), .clk_int_sel_o(clk_int_sel_o));

/* pmr_ctrl_tb.sv */
// Purpose: self-checking bench for pmr_ctrl
// Assumes: release delay shortened to POR cycles
// Notes: reads are scored from a queue by a monitor process
`timescale 1ns/10ps
module pmr_ctrl_tb;
    import pmr_pkg::*;
    localparam int POR = 20;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, port_latch_o;
    logic supply_up = 1'b0, ext_hold = 1'b0, other_rst_i = 1'b0, instr_done_i = 1'b0, irq_pending_i = 1'b0;
    logic supply_ok, pin_lvl, rst_pin_o, rst_pin_oe_n_o, core_reset_o, cpu_clk_en_o, periph_clk_en_o;
    logic osc_run_o, port_force_o, reset_exit_o, clk_int_sel_o, drove = 1'b0;
    logic [15:0] boot_addr_o;
    logic [3:0] wdt_div_o;
    logic [5:0] gf;
    logic [15:0] exp_q[$], nx;
    int miscompares = 0, num_checks = 0, n;
    always #5 sys_clk_i = ~sys_clk_i;
    pmr_rail_model pmr_rail_model_inst (.supply_up_i(supply_up), .ext_hold_i(ext_hold), .drv_i(rst_pin_o),
        .oe_n_i(rst_pin_oe_n_o), .supply_ok_o(supply_ok), .pin_o(pin_lvl));
    pmr_ctrl #(.POR_DELAY_CYC(POR)) pmr_ctrl_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .supply_ok_i(supply_ok), .rst_pin_i(pin_lvl), .rst_pin_o(rst_pin_o),
        .rst_pin_oe_n_o(rst_pin_oe_n_o), .other_rst_i(other_rst_i), .instr_done_i(instr_done_i),
        .irq_pending_i(irq_pending_i), .core_reset_o(core_reset_o), .cpu_clk_en_o(cpu_clk_en_o),
        .periph_clk_en_o(periph_clk_en_o), .osc_run_o(osc_run_o), .port_force_o(port_force_o),
        .port_latch_o(port_latch_o), .reset_exit_o(reset_exit_o), .boot_addr_o(boot_addr_o),
        .wdt_div_o(wdt_div_o), .clk_int_sel_o(clk_int_sel_o));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        sfr_wr_i = 1'b0;
    endtask
    // masked compare, so indeterminate cause flags do not count
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge sys_clk_i);
        #1;
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        exp_q.push_back({m, e});
        @(posedge sys_clk_i);
        #1;
        sfr_rd_i = 1'b0;
        #10;
    endtask
    // bounded wait: sel 0 for reset entry, 1 for the exit pulse
    task automatic wait_for(input bit sel, output int k);
        k = 0;
        while (((sel ? reset_exit_o : core_reset_o) !== 1'b1) && k < 200) begin
            @(posedge sys_clk_i);
            #2;
            k++;
        end
        if (k >= 200) miscompares++;
    endtask
    // read data lands on the taken edge, checked 2 ns after it
    always @(posedge sys_clk_i) begin
        if (sfr_rd_i === 1'b1) begin
            #2;
            nx = exp_q.pop_front();
            check(sfr_rdata_o & nx[15:8], nx[7:0]);
        end
    end
    // remembers any pin drive seen while the core is held
    always @(posedge sys_clk_i) if (core_reset_o === 1'b1 && rst_pin_oe_n_o === 1'b0) drove <= 1'b1;
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(59));
        repeat (5) @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        repeat (8) @(posedge sys_clk_i);
        #2 check({7'h00, rst_pin_oe_n_o}, 8'h00);
        check({7'h00, port_force_o}, 8'h01);
        supply_up = 1'b1;
        wait_for(1'b1, n);
        check({7'h00, n >= POR + 2 && n <= POR + 6}, 8'h01);
        check({7'h00, clk_int_sel_o}, 8'h01);
        check({4'h0, wdt_div_o}, {4'h0, PMR_WDT_DIV});
        check(port_latch_o, PMR_PORT_RST_VAL);
        rd(PMR_ADDR_ORIGIN, 8'h02, 8'h02);
        rd(PMR_ADDR_PWR_CTRL, 8'hFF, PMR_PWR_CTRL_RST);
        rd(PMR_ADDR_MON_CTRL, 8'hFF, 8'hC0);
        rd(8'h55, 8'hFF, 8'h00);
        // flags, then idle entry on the next finished instruction
        gf = 6'($urandom());
        wr(PMR_ADDR_PWR_CTRL, {gf, 2'b00});
        rd(PMR_ADDR_PWR_CTRL, 8'hFF, {gf, 2'b00});
        wr(PMR_ADDR_PWR_CTRL, {gf, 2'b01});
        #1 check({7'h00, cpu_clk_en_o}, 8'h01);
        instr_done_i = 1'b1;
        @(posedge sys_clk_i);
        #1 instr_done_i = 1'b0;
        #1 check({6'h00, cpu_clk_en_o, periph_clk_en_o}, 8'h01);
        rd(PMR_ADDR_PWR_CTRL, 8'hFF, {gf, 2'b00});
        irq_pending_i = 1'b1;
        @(posedge sys_clk_i);
        #2 check({7'h00, cpu_clk_en_o}, 8'h01);
        irq_pending_i = 1'b0;
        // monitor trip: enable first, select second, then sag the rail
        wr(PMR_ADDR_MON_CTRL, 8'h80);
        wr(PMR_ADDR_ORIGIN, 8'h02);
        supply_up = 1'b0;
        wait_for(1'b0, n);
        check({7'h00, rst_pin_oe_n_o}, 8'h00);
        repeat (3) @(posedge sys_clk_i);
        supply_up = 1'b1;
        wait_for(1'b1, n);
        check({7'h00, n <= 5}, 8'h01);
        rd(PMR_ADDR_ORIGIN, 8'h02, 8'h00);
        // software reset with the monitor switched off
        wr(PMR_ADDR_MON_CTRL, 8'h00);
        drove = 1'b0;
        wr(PMR_ADDR_ORIGIN, 8'h10);
        wait_for(1'b1, n);
        rd(PMR_ADDR_MON_CTRL, 8'h80, 8'h00);
        rd(PMR_ADDR_ORIGIN, 8'h12, 8'h10);
        rd(PMR_ADDR_PWR_CTRL, 8'hFF, 8'h00);
        // external pin reset
        ext_hold = 1'b1;
        wait_for(1'b0, n);
        repeat (3) @(posedge sys_clk_i);
        #1 ext_hold = 1'b0;
        wait_for(1'b1, n);
        check({7'h00, drove}, 8'h00);
        rd(PMR_ADDR_ORIGIN, 8'h03, 8'h01);
        // stop survives an interrupt, only a reset ends it
        wr(PMR_ADDR_PWR_CTRL, 8'h02);
        instr_done_i = 1'b1;
        @(posedge sys_clk_i);
        #1 instr_done_i = 1'b0;
        irq_pending_i = 1'b1;
        #1 check({6'h00, osc_run_o, periph_clk_en_o}, 8'h00);
        repeat (3) @(posedge sys_clk_i);
        #2 check({7'h00, cpu_clk_en_o}, 8'h00);
        irq_pending_i = 1'b0;
        other_rst_i = 1'b1;
        wait_for(1'b0, n);
        other_rst_i = 1'b0;
        wait_for(1'b1, n);
        check({7'h00, osc_run_o}, 8'h01);
        rd(PMR_ADDR_ORIGIN, 8'h02, 8'h00);
        // second power-on in mid-run turns the monitor back on
        @(posedge sys_clk_i);
        #1 rst_n_i = 1'b0; // no memory value relied on
        repeat (5) @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        wait_for(1'b1, n);
        rd(PMR_ADDR_MON_CTRL, 8'h80, 8'h80);
        rd(PMR_ADDR_ORIGIN, 8'h02, 8'h02);
        wrap_up();
    end
    // hang guard, far beyond the 150 or so cycles the run needs
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
endmodule
